// ===== debug_host_model.sv
// serial background debug host model: single byte writes on the debug port
// assumes the target samples the debug port on the rising edge of ref_clk_in
`timescale 1ns/10ps
`default_nettype none
module debug_host_model
  import reset_cause_pkg::*;
(
  // clock
  input wire logic ref_clk_in,
  // debug byte write port
  output logic dbg_wr_en_out,
  output logic [REG_ADDR_W-1:0] dbg_addr_out,
  output logic [7:0] dbg_wdata_out
);
  // ----------------------------------------------------------------
  // idle state
  // ----------------------------------------------------------------
  // the port starts idle with no strobe
  initial begin
    dbg_wr_en_out = 1'b0;
    dbg_addr_out = '0;
    dbg_wdata_out = 8'h00;
  end

  // ----------------------------------------------------------------
  // byte write command
  // ----------------------------------------------------------------
  // drives after a falling edge, holds across one rising edge, then releases;
  // a forced target reset is only ever asked for through this command
  task automatic byte_write(input logic [REG_ADDR_W-1:0] addr, input logic [7:0] data);
    @(negedge ref_clk_in);
    dbg_wr_en_out = 1'b1;
    dbg_addr_out = addr;
    dbg_wdata_out = data;
    @(negedge ref_clk_in);
    dbg_wr_en_out = 1'b0;
    // released lines show the inverse so stale values are never trusted
    dbg_addr_out = ~addr;
    dbg_wdata_out = ~data;
  endtask : byte_write
endmodule : debug_host_model
`default_nettype wire

// ===== reset_cause_ctrl.sv
// reset cause capture, watchdog service decode and debug forced reset
// assumes srst_in is the power-on reset and all event inputs except the pin
// and the low-voltage comparator come from logic on ref_clk_in
//
// How it works
// RULE_01: read-only flags record most recent reset source
// RULE_02: debug forced reset leaves every flag cleared
// RULE_03: bad write while watchdog enabled triggers reset
// RULE_04: 0x55 then 0xaa restarts watchdog, flags unchanged
// RULE_05: power-on sets bits 7 and 1 only
// RULE_06: low-voltage reset sets bit 1, keeps bit 7
// RULE_07: other resets copy active sources into bits 6-2
// RULE_08: low external reset pin sets bit 6
// RULE_09: watchdog timeout sets bit 5 when enabled
// RULE_10: illegal opcode, halt or debug entry sets bit 4
// RULE_11: illegal address access sets bit 3
// RULE_12: lost timing reference sets bit 2
// RULE_13: program writes to force register are ignored
// RULE_14: force register always reads zero
// RULE_15: debug write of one forces system reset
// RULE_16: host forces reset only through debug byte write
// RULE_17: status bit 0 always reads zero
`timescale 1ns/10ps
`default_nettype none
module reset_cause_ctrl
  import reset_cause_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // processor register port
  input wire logic cpu_wr_en_in,
  input wire logic cpu_rd_en_in,
  input wire logic [REG_ADDR_W-1:0] cpu_addr_in,
  input wire logic [7:0] cpu_wdata_in,
  output logic [7:0] cpu_rdata_out,
  // serial debug register port
  input wire logic dbg_wr_en_in,
  input wire logic [REG_ADDR_W-1:0] dbg_addr_in,
  input wire logic [7:0] dbg_wdata_in,
  // option settings
  input wire logic watchdog_enable_setting_in,
  input wire logic low_voltage_reset_enable_in,
  input wire logic halt_mode_enable_in,
  input wire logic debug_mode_enable_in,
  // reset sources
  input wire logic ext_reset_n_in,
  input wire logic low_voltage_trip_in,
  input wire logic watchdog_timeout_in,
  input wire logic opcode_unimpl_in,
  input wire logic halt_instr_in,
  input wire logic debug_entry_instr_in,
  input wire logic illegal_address_in,
  input wire logic lost_reference_in,
  // results
  output logic sys_reset_out,
  output logic watchdog_restart_out
);

  // ----------------------------------------------------------------
  // address decode shared by both ports
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic en, input logic [REG_ADDR_W-1:0] addr,
                                    input logic [REG_ADDR_W-1:0] target);
    addr_hit = en && (addr == target);
  endfunction : addr_hit

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0] pad_sync;             // synchronised pin and comparator levels
  logic ext_reset_n_sync;           // external reset pin, low active
  logic low_voltage_sync;           // supply under trip level
  logic [7:0] status_reg;           // reset_cause_status
  logic [7:0] status_next;
  logic [7:0] rdata_next;
  service_state_t svc_reg;          // watchdog service sequence
  service_state_t svc_next;
  logic restart_next;
  logic cpu_status_wr;              // program write to the status address
  logic cpu_ctrl_wr;                // program write to the force register
  logic dbg_force;                  // debug link asks for forced reset
  logic bad_service_write;          // write other than a service value
  logic src_pin;                    // per-source reset causes
  logic src_watchdog;
  logic src_illegal_op;
  logic src_illegal_addr;
  logic src_lost_ref;
  logic src_low_voltage;
  logic any_source;                 // some source demands reset
  logic reset_entry;                // one-cycle capture moment

  // ----------------------------------------------------------------
  // pad level synchronisers
  // ----------------------------------------------------------------
  two_stage_sync #(
    .W(2),
    .RESET_VAL(2'h2)
  ) u_pad_sync (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .async_in({ext_reset_n_in, low_voltage_trip_in}),
    .sync_out(pad_sync)
  );
  assign ext_reset_n_sync = pad_sync[1];
  assign low_voltage_sync = pad_sync[0];

  // ----------------------------------------------------------------
  // reset hold timer; drives sys_reset_out from its flip-flop
  // ----------------------------------------------------------------
  reset_hold_timer u_hold (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .start_in(reset_entry),
    .busy_out(sys_reset_out)
  );

  // ----------------------------------------------------------------
  // access decode; program status writes are blocked while the reset stands, reads are not
  // ----------------------------------------------------------------
  assign cpu_status_wr = addr_hit(cpu_wr_en_in, cpu_addr_in, ADDR_CAUSE_STATUS) && !sys_reset_out;
  assign cpu_ctrl_wr = addr_hit(cpu_wr_en_in, cpu_addr_in, ADDR_FORCE_CTRL);
  // program writes to the force register reach nothing [RULE_13]
  // only the debug link can set the force bit [RULE_15] [RULE_16]
  assign dbg_force = addr_hit(dbg_wr_en_in, dbg_addr_in, ADDR_FORCE_CTRL)
                     && dbg_wdata_in[BIT_FORCE_RESET];

  // any value but the two service values, while enabled [RULE_03]
  assign bad_service_write = cpu_status_wr && watchdog_enable_setting_in
                             && (cpu_wdata_in != SERVICE_FIRST)
                             && (cpu_wdata_in != SERVICE_SECOND);

  // ----------------------------------------------------------------
  // reset source qualification
  // ----------------------------------------------------------------
  assign src_pin = !ext_reset_n_sync;                                      // [RULE_08]
  // watchdog source blocked while the enable setting is zero [RULE_09]
  assign src_watchdog = watchdog_enable_setting_in && (watchdog_timeout_in || bad_service_write);
  // halt and debug entry count as illegal when their modes are off [RULE_10]
  assign src_illegal_op = opcode_unimpl_in
                          || (halt_instr_in && !halt_mode_enable_in)
                          || (debug_entry_instr_in && !debug_mode_enable_in);
  assign src_illegal_addr = illegal_address_in;                            // [RULE_11]
  assign src_lost_ref = lost_reference_in;                                 // [RULE_12]
  assign src_low_voltage = low_voltage_reset_enable_in && low_voltage_sync; // [RULE_06]
  assign any_source = src_pin || src_watchdog || src_illegal_op || src_illegal_addr
                      || src_lost_ref || src_low_voltage || dbg_force;
  // sources are sampled once, at the first cycle of a new reset
  assign reset_entry = any_source && !sys_reset_out;

  // ----------------------------------------------------------------
  // status capture at reset entry
  // ----------------------------------------------------------------
  always_comb begin
    status_next = status_reg;
    if (reset_entry) begin
      if (src_low_voltage) begin
        // low-voltage: bit 1 set, power-on kept, rest cleared [RULE_06]
        status_next = BYTE_ZERO;
        status_next[BIT_POWER_ON] = status_reg[BIT_POWER_ON];
        status_next[BIT_LOW_VOLTAGE] = 1'b1;
      end else if (dbg_force) begin
        // debug forced reset leaves every flag clear [RULE_02]
        status_next = BYTE_ZERO;
      end else begin
        // every active source sets its flag, others clear [RULE_07] [RULE_01]
        status_next = BYTE_ZERO;
        status_next[BIT_EXT_PIN] = src_pin;                 // [RULE_08]
        status_next[BIT_WATCHDOG] = src_watchdog;           // [RULE_09]
        status_next[BIT_ILLEGAL_OP] = src_illegal_op;       // [RULE_10]
        status_next[BIT_ILLEGAL_ADDR] = src_illegal_addr;   // [RULE_11]
        status_next[BIT_LOST_REF] = src_lost_ref;           // [RULE_12]
      end
    end
    status_next[BIT_UNUSED] = 1'b0;                         // [RULE_17]
  end

  // ----------------------------------------------------------------
  // watchdog service sequence; never touches the flags [RULE_04]
  // ----------------------------------------------------------------
  always_comb begin
    svc_next = svc_reg;
    restart_next = 1'b0;
    if (cpu_status_wr) begin
      if (cpu_wdata_in == SERVICE_FIRST) begin
        svc_next = SVC_ARMED;
      end else begin
        case (svc_reg)
          SVC_ARMED: begin
            // second value right after the first restarts the count [RULE_04]
            restart_next = (cpu_wdata_in == SERVICE_SECOND);
            svc_next = SVC_IDLE;
          end
          SVC_IDLE: begin
            svc_next = SVC_IDLE;
          end
          default: begin
            svc_next = SVC_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // read data; force register always reads zero [RULE_14]
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = BYTE_ZERO;
    if (addr_hit(cpu_rd_en_in, cpu_addr_in, ADDR_CAUSE_STATUS)) begin
      rdata_next = status_reg;                              // [RULE_01]
    end
  end

  // ----------------------------------------------------------------
  // registers; power-on reset loads the power-on pattern [RULE_05]
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      status_reg <= STATUS_POR_VALUE;                       // [RULE_05]
      svc_reg <= SVC_IDLE;
      watchdog_restart_out <= 1'b0;
      cpu_rdata_out <= BYTE_ZERO;
    end else begin
      status_reg <= status_next;
      svc_reg <= svc_next;
      watchdog_restart_out <= restart_next;
      cpu_rdata_out <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_debug_clears;
    @(posedge ref_clk_in) disable iff (srst_in)
    (reset_entry && dbg_force && !src_low_voltage) |=> (status_reg == BYTE_ZERO);
  endproperty
  a_debug_clears: assert property (p_debug_clears) // [RULE_02]
    else $error("debug forced reset left a flag set");

  property p_bad_write;
    @(posedge ref_clk_in) disable iff (srst_in)
    (bad_service_write && !src_low_voltage && !dbg_force)
      |=> (sys_reset_out && status_reg[BIT_WATCHDOG]);
  endproperty
  a_bad_write: assert property (p_bad_write) // [RULE_03]
    else $error("bad service write did not reset");

  property p_service;
    @(posedge ref_clk_in) disable iff (srst_in)
    (svc_reg == SVC_ARMED && cpu_status_wr && cpu_wdata_in == SERVICE_SECOND && !any_source)
      |=> (watchdog_restart_out && $stable(status_reg));
  endproperty
  a_service: assert property (p_service) // [RULE_04]
    else $error("service sequence failed or changed flags");

  property p_power_on;
    @(posedge ref_clk_in)
    srst_in |=> (status_reg == STATUS_POR_VALUE);
  endproperty
  a_power_on: assert property (p_power_on) // [RULE_05]
    else $error("power-on pattern wrong");

  property p_low_voltage;
    @(posedge ref_clk_in) disable iff (srst_in)
    (reset_entry && src_low_voltage) |=> (status_reg[BIT_LOW_VOLTAGE]
      && status_reg[BIT_POWER_ON] == $past(status_reg[BIT_POWER_ON])
      && status_reg[BIT_EXT_PIN:BIT_LOST_REF] == 5'h00);
  endproperty
  a_low_voltage: assert property (p_low_voltage) // [RULE_06]
    else $error("low-voltage capture wrong");

  property p_pin;
    @(posedge ref_clk_in) disable iff (srst_in)
    (reset_entry && src_pin && !src_low_voltage && !dbg_force)
      |=> (status_reg[BIT_EXT_PIN] && !status_reg[BIT_POWER_ON]);
  endproperty
  a_pin: assert property (p_pin) // [RULE_08]
    else $error("pin reset flag missing");

  property p_watchdog_gate;
    @(posedge ref_clk_in) disable iff (srst_in)
    (reset_entry && !watchdog_enable_setting_in) |=> !status_reg[BIT_WATCHDOG];
  endproperty
  a_watchdog_gate: assert property (p_watchdog_gate) // [RULE_09]
    else $error("watchdog flag set while disabled");

  property p_halt_illegal;
    @(posedge ref_clk_in) disable iff (srst_in)
    (!sys_reset_out && halt_instr_in && !halt_mode_enable_in && !src_low_voltage && !dbg_force)
      |=> (sys_reset_out && status_reg[BIT_ILLEGAL_OP]) [*1] ##1 sys_reset_out;
  endproperty
  a_halt_illegal: assert property (p_halt_illegal) // [RULE_10]
    else $error("disabled halt did not give illegal opcode reset");

  property p_cpu_ctrl_ignored;
    @(posedge ref_clk_in) disable iff (srst_in)
    (cpu_ctrl_wr && !any_source && !sys_reset_out) |=> !sys_reset_out;
  endproperty
  a_cpu_ctrl_ignored: assert property (p_cpu_ctrl_ignored) // [RULE_13]
    else $error("program write forced a reset");

  property p_ctrl_reads_zero;
    @(posedge ref_clk_in) disable iff (srst_in)
    addr_hit(cpu_rd_en_in, cpu_addr_in, ADDR_FORCE_CTRL) |=> (cpu_rdata_out == BYTE_ZERO);
  endproperty
  a_ctrl_reads_zero: assert property (p_ctrl_reads_zero) // [RULE_14]
    else $error("force register read nonzero");

  property p_debug_force;
    @(posedge ref_clk_in) disable iff (srst_in)
    (dbg_force && !sys_reset_out) |=> sys_reset_out [*8];
  endproperty
  a_debug_force: assert property (p_debug_force) // [RULE_15]
    else $error("debug force did not hold reset");

  property p_bit0_zero;
    @(posedge ref_clk_in) disable iff (srst_in)
    addr_hit(cpu_rd_en_in, cpu_addr_in, ADDR_CAUSE_STATUS) |=> !cpu_rdata_out[BIT_UNUSED];
  endproperty
  a_bit0_zero: assert property (p_bit0_zero) // [RULE_17]
    else $error("status bit 0 set");

endmodule : reset_cause_ctrl
`default_nettype wire

// ===== reset_cause_pkg.sv
// constants, field layouts and types shared by the reset cause block
// assumes a single 10 MHz bus clock and an 8-bit register view
package reset_cause_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;   // bus clock period
  localparam int RESET_HOLD_NS = 800;   // least time the system reset is held
  // least time rounds up to whole cycles, never below one
  localparam int RESET_HOLD_RAW = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_RAW < 1) ? 1 : RESET_HOLD_RAW;
  localparam int HOLD_CNT_W = 4;        // wide enough for the hold count
  localparam logic [HOLD_CNT_W-1:0] HOLD_LOAD = 4'(RESET_HOLD_CYCLES - 1);
  localparam logic [HOLD_CNT_W-1:0] HOLD_ZERO = 4'h0;

  // ----------------------------------------------------------------
  // register addresses (one select bit, no offsets are printed)
  // ----------------------------------------------------------------
  localparam int REG_ADDR_W = 1;
  localparam logic [REG_ADDR_W-1:0] ADDR_CAUSE_STATUS = 1'h0;  // reset_cause_status
  localparam logic [REG_ADDR_W-1:0] ADDR_FORCE_CTRL = 1'h1;    // debug_force_reset_control

  // ----------------------------------------------------------------
  // reset_cause_status field positions
  // ----------------------------------------------------------------
  localparam int BIT_POWER_ON = 7;
  localparam int BIT_EXT_PIN = 6;
  localparam int BIT_WATCHDOG = 5;
  localparam int BIT_ILLEGAL_OP = 4;
  localparam int BIT_ILLEGAL_ADDR = 3;
  localparam int BIT_LOST_REF = 2;
  localparam int BIT_LOW_VOLTAGE = 1;
  localparam int BIT_UNUSED = 0;
  localparam int BIT_FORCE_RESET = 0;   // debug_force_reset_bit

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_POR_VALUE = 8'h82;  // power-on and low-voltage set
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] SERVICE_FIRST = 8'h55;     // first watchdog service value
  localparam logic [7:0] SERVICE_SECOND = 8'haa;    // second watchdog service value

  // watchdog service sequence tracker
  typedef enum logic [0:0] {
    SVC_IDLE = 1'b0,
    SVC_ARMED = 1'b1
  } service_state_t;

endpackage : reset_cause_pkg

// ===== reset_hold_timer.sv
// holds the system reset request for a fixed number of bus cycles
// assumes start is a one-cycle pulse from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module reset_hold_timer
  import reset_cause_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // control
  input wire logic start_in,
  output logic busy_out
);

  logic [HOLD_CNT_W-1:0] cnt_reg;   // cycles left in the hold
  logic [HOLD_CNT_W-1:0] cnt_next;
  logic busy_next;

  // ----------------------------------------------------------------
  // next state: load on start, count down while busy
  // ----------------------------------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_out;
    if (start_in && !busy_out) begin
      cnt_next = HOLD_LOAD;
      busy_next = 1'b1;
    end else if (busy_out) begin
      if (cnt_reg == HOLD_ZERO) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cnt_reg <= HOLD_ZERO;
      busy_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_out <= busy_next;
    end
  end

endmodule : reset_hold_timer
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the reset cause block and its debug forced reset
// assumes the package, the design files and debug_host_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench
  import reset_cause_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic ref_clk_in = 1'b0;
  logic srst_in, cpu_wr_en_in, cpu_rd_en_in;
  logic [REG_ADDR_W-1:0] cpu_addr_in;
  logic [7:0] cpu_wdata_in, cpu_rdata_out;
  logic dbg_wr_en, sys_reset_out, watchdog_restart_out;
  logic [REG_ADDR_W-1:0] dbg_addr;
  logic [7:0] dbg_wdata;
  logic we, lvre, hen, den; // option levels
  logic [7:0] src; // 7 pin low, 6 trip, 5 wdog, 4 opcode, 3 halt, 2 dbg entry, 1 addr, 0 ref
  logic [7:0] rd;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;

  // clock: 100 ns period
  always #50 ref_clk_in = ~ref_clk_in;

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  reset_cause_ctrl u_reset_cause_ctrl (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .cpu_wr_en_in(cpu_wr_en_in), .cpu_rd_en_in(cpu_rd_en_in), .cpu_addr_in(cpu_addr_in),
    .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out),
    .dbg_wr_en_in(dbg_wr_en), .dbg_addr_in(dbg_addr), .dbg_wdata_in(dbg_wdata),
    .watchdog_enable_setting_in(we), .low_voltage_reset_enable_in(lvre),
    .halt_mode_enable_in(hen), .debug_mode_enable_in(den),
    .ext_reset_n_in(~src[7]), .low_voltage_trip_in(src[6]), .watchdog_timeout_in(src[5]),
    .opcode_unimpl_in(src[4]), .halt_instr_in(src[3]), .debug_entry_instr_in(src[2]),
    .illegal_address_in(src[1]), .lost_reference_in(src[0]),
    .sys_reset_out(sys_reset_out), .watchdog_restart_out(watchdog_restart_out)
  );
  debug_host_model u_debug_host_model (
    .ref_clk_in(ref_clk_in), .dbg_wr_en_out(dbg_wr_en), .dbg_addr_out(dbg_addr),
    .dbg_wdata_out(dbg_wdata)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // verdict and end of run
  task automatic end_sim();
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // compares one value and counts it
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // read: strobe for one edge, data taken in the following cycle
  task automatic cpu_read(input logic [REG_ADDR_W-1:0] a, output logic [7:0] d);
    cpu_rd_en_in = 1'b1;
    cpu_addr_in = a;
    @(negedge ref_clk_in);
    cpu_rd_en_in = 1'b0;
    d = cpu_rdata_out;
    @(negedge ref_clk_in);
  endtask : cpu_read

  // write: strobe left high so writes run back to back; caller drops it
  task automatic cpu_write(input logic [REG_ADDR_W-1:0] a, input logic [7:0] d);
    cpu_wr_en_in = 1'b1;
    cpu_addr_in = a;
    cpu_wdata_in = d;
    @(negedge ref_clk_in);
  endtask : cpu_write

  // watches reset and restart pulses for 16 cycles, then reads status
  task automatic settle(input logic exp_rst, input logic [7:0] exp_p, input logic [7:0] exp_s);
    logic r;
    logic [7:0] p;
    r = 1'b0;
    p = 8'h00;
    repeat (16) begin
      if (sys_reset_out === 1'b1) r = 1'b1;
      if (watchdog_restart_out === 1'b1) p = p + 8'h01;
      @(negedge ref_clk_in);
    end
    check({7'h00, r}, {7'h00, exp_rst});
    check(p, exp_p);
    cpu_read(ADDR_CAUSE_STATUS, rd);
    check(rd, exp_s);
  endtask : settle

  // raises reset sources for four cycles
  task automatic run_case(input logic [7:0] s, input logic exp_rst, input logic [7:0] exp_s);
    src = s;
    repeat (4) @(negedge ref_clk_in);
    src = 8'h00;
    settle(exp_rst, 8'h00, exp_s);
  endtask : run_case

  // one or two program writes, or one debug byte write
  task automatic act(input logic dbg, input logic [REG_ADDR_W-1:0] a, input logic [7:0] d0,
                     input logic [7:0] d1, input logic two, input logic exp_rst,
                     input logic [7:0] exp_p, input logic [7:0] exp_s);
    if (dbg) begin
      u_debug_host_model.byte_write(a, d0);
    end else begin
      cpu_write(a, d0);
      if (two) cpu_write(a, d1);
      cpu_wr_en_in = 1'b0;
    end
    settle(exp_rst, exp_p, exp_s);
  endtask : act

  // ----------------------------------------------------------------
  // hang guard
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst_in = 1'b1;
    {cpu_wr_en_in, cpu_rd_en_in, cpu_addr_in, cpu_wdata_in} = '0;
    {we, lvre, hen, den} = 4'h0;
    src = 8'h00;
    repeat (2) @(negedge ref_clk_in);
    srst_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    settle(1'b0, 8'h00, STATUS_POR_VALUE);
    cpu_read(ADDR_FORCE_CTRL, rd);
    check(rd, 8'h00);
    we = 1'b1;
    lvre = 1'b1;
    act(1'b0, ADDR_CAUSE_STATUS, 8'h55, 8'haa, 1'b1, 1'b0, 8'h01, 8'h82);
    act(1'b0, ADDR_CAUSE_STATUS, 8'haa, 8'h00, 1'b0, 1'b0, 8'h00, 8'h82);
    act(1'b0, ADDR_FORCE_CTRL, 8'h01, 8'h00, 1'b0, 1'b0, 8'h00, 8'h82);
    run_case(8'h40, 1'b1, 8'h82);
    lvre = 1'b0;
    run_case(8'h40, 1'b0, 8'h82);
    act(1'b0, ADDR_CAUSE_STATUS, 8'h55, 8'h12, 1'b1, 1'b1, 8'h00, 8'h20);
    run_case(8'h80, 1'b1, 8'h40);
    run_case(8'h20, 1'b1, 8'h20);
    we = 1'b0;
    run_case(8'h20, 1'b0, 8'h20);
    act(1'b0, ADDR_CAUSE_STATUS, 8'h12, 8'h00, 1'b0, 1'b0, 8'h00, 8'h20);
    // watchdog blocked while disabled, the address source still captured
    run_case(8'h22, 1'b1, 8'h08);
    we = 1'b1;
    run_case(8'h10, 1'b1, 8'h10);
    run_case(8'h08, 1'b1, 8'h10);
    run_case(8'h04, 1'b1, 8'h10);
    hen = 1'b1;
    den = 1'b1;
    run_case(8'h0c, 1'b0, 8'h10);
    run_case(8'h02, 1'b1, 8'h08);
    run_case(8'h01, 1'b1, 8'h04);
    run_case(8'h22, 1'b1, 8'h28);
    act(1'b1, ADDR_FORCE_CTRL, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 8'h28);
    act(1'b1, ADDR_FORCE_CTRL, 8'h01, 8'h00, 1'b0, 1'b1, 8'h00, 8'h00);
    lvre = 1'b1;
    run_case(8'h40, 1'b1, 8'h02);
    end_sim();
  end
endmodule : testbench
`default_nettype wire

// ===== two_stage_sync.sv
// two flip-flop synchroniser for levels arriving from outside the clock domain
// assumes the inputs are quasi-static levels; only the second stage is used
`timescale 1ns/10ps
`default_nettype none
module two_stage_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;  // first stage, read only by the second stage

  // ----------------------------------------------------------------
  // both stages
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : two_stage_sync
`default_nettype wire
